// ---- rtl/frac_ctrl.sv ----
// frac_ctrl: reference source selection and autotuning mode control,
// with an axi4-lite register slave and one level interrupt.
// assumes keys, inputs and sources are synchronous to i_ref_clk; the
// analog measurement and constant arithmetic live outside this block.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module frac_ctrl
  import frac_pkg::*;
#(
  parameter bit POT_PANEL = 1'b0,
  parameter longint ROT_CYC = frac_pkg::ROT_PHASE_CYC,
  parameter longint STAT_CYC = frac_pkg::STAT_PHASE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic o_irq,
  // panel
  input wire logic i_remote,
  input wire logic i_key_run,
  input wire logic i_key_stop,
  input wire logic i_display_key,
  input wire logic i_key_enter,
  input wire logic [frac_pkg::REF_W-1:0] i_key_value,
  input wire logic i_key_value_upd,
  output logic o_err_ind,
  output logic o_tuning,
  // sources
  input wire logic [frac_pkg::REF_W-1:0] i_pot,
  input wire logic [frac_pkg::REF_W-1:0] i_volt,
  input wire logic [frac_pkg::REF_W-1:0] i_cur420,
  input wire logic [frac_pkg::REF_W-1:0] i_cur020,
  input wire logic [frac_pkg::REF_W-1:0] i_pulse,
  input wire logic [frac_pkg::REF_W-1:0] i_comm,
  input wire logic [frac_pkg::REF_W-1:0] i_conn_volt,
  input wire logic [frac_pkg::REF_W-1:0] i_conn_cur,
  input wire logic [frac_pkg::REF_W-1:0] i_card,
  output logic [frac_pkg::REF_W-1:0] o_freq_ref,
  // multi-function io and measurement
  input wire logic [7:0] i_mf_in,
  output logic [7:0] o_mf_in_eff,
  input wire logic i_motor2_sel,
  input wire logic [7:0] i_mf_out_norm,
  output logic [7:0] o_mf_out,
  input wire logic [15:0] i_meas_resist,
  input wire logic i_meas_err,
  output logic o_motor_energise,
  output logic o_motor_rotate
);
  import frac_pkg::*;

  logic local_ref_source_sel;
  logic enter_commit_option;
  logic [3:0] remote_ref_source_sel;
  logic [REF_W-1:0] preset_freq_ref_one;
  logic [1:0] tuning_mode_sel;
  logic [15:0] winding_resistance_const;
  logic [15:0] resist_saved;
  logic [REF_W-1:0] keyed_ref;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [7:0] mf_out_frozen;
  frac_state_t state;
  logic [TMR_W-1:0] tmr;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic ev_done;
  logic ev_cancel;
  logic ev_err;
  logic busy;

  function automatic logic tmr_end(input logic [TMR_W-1:0] t, input longint lim);
    tmr_end = (t == TMR_W'(lim - 1));
  endfunction

  assign busy = (state == ST_HOLD) || (state == ST_SPIN) || (state == ST_ENERGISE);

  // write channel: address and data captured in either order
  // readies gated by the enable, so a frozen slave never shows a false handshake
  assign s_axi_awready = i_ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = i_ce && !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
    end else if (i_ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'b00;

  // read channel: one cycle latency, unmapped reads return zero
  assign s_axi_arready = i_ce && !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
    end else if (i_ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        case (s_axi_araddr)
          ADDR_CFG: s_axi_rdata <= {24'h0, remote_ref_source_sel, 2'b00,
                                    enter_commit_option, local_ref_source_sel};
          ADDR_TUNE: s_axi_rdata <= {30'h0, tuning_mode_sel};
          ADDR_STAT: s_axi_rdata <= {27'h0, i_motor2_sel, busy, state};
          ADDR_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
          ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
          ADDR_PRESET: s_axi_rdata <= {16'h0, preset_freq_ref_one};
          ADDR_RESIST: s_axi_rdata <= {16'h0, winding_resistance_const};
          ADDR_KEYED: s_axi_rdata <= {16'h0, keyed_ref};
          default: s_axi_rdata <= '0;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // source selections; locked while tuning so the reference cannot jump
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      local_ref_source_sel <= POT_PANEL ? LOCAL_SRC_POT : LOCAL_SRC_KEYPAD;
      remote_ref_source_sel <= POT_PANEL ? REM_SRC_POT : REM_SRC_PRESET;
      enter_commit_option <= 1'b0;
      preset_freq_ref_one <= '0;
      irq_mask <= '0;
    end else if (i_ce && do_write && w_strb[0]) begin
      if (aw_addr == ADDR_CFG && !busy) begin
        local_ref_source_sel <= w_data[CFG_LOCAL_BIT];
        enter_commit_option <= w_data[CFG_ENTER_BIT];
        if (w_data[CFG_REM_LSB +: CFG_REM_W] <= REM_SRC_MAX) begin
          remote_ref_source_sel <= w_data[CFG_REM_LSB +: CFG_REM_W];
        end
      end
      if (aw_addr == ADDR_IRQ_MASK) begin
        irq_mask <= w_data[IRQ_W-1:0];
      end
      if (aw_addr == ADDR_PRESET) begin
        preset_freq_ref_one <= w_data[REF_W-1:0];
      end
    end
  end

  // keyed value: enter commits, or immediate when the option is set
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      keyed_ref <= '0;
    end else if (i_ce && state == ST_PROG && i_key_value_upd) begin
      if (enter_commit_option || i_key_enter) begin
        keyed_ref <= i_key_value;
      end
    end
  end

  // tuning mode: refused while busy or while motor 2 is selected
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tuning_mode_sel <= TUNE_OFF;
    end else if (i_ce && do_write && w_strb[0] && aw_addr == ADDR_TUNE) begin
      if (!busy && !i_motor2_sel && w_data[1:0] <= TUNE_MAX) begin
        tuning_mode_sel <= w_data[1:0];
      end
    end
  end
  assign ev_err = i_ce && do_write && w_strb[0] && aw_addr == ADDR_TUNE &&
                  (i_motor2_sel || w_data[1:0] > TUNE_MAX);

  // tuning sequencer; only run, display and stop keys act here
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state <= ST_PROG;
      tmr <= '0;
    end else if (i_ce) begin
      case (state)
        ST_PROG: begin
          if (i_display_key && tuning_mode_sel != TUNE_OFF && !i_motor2_sel) begin
            state <= ST_READY;
          end
        end
        ST_READY: begin
          tmr <= '0;
          if (i_key_stop || i_display_key) begin
            state <= ST_PROG;
          end else if (i_key_run) begin
            state <= (tuning_mode_sel == TUNE_ROT) ? ST_HOLD : ST_ENERGISE;
          end
        end
        ST_HOLD: begin
          tmr <= tmr + 1'b1;
          if (i_key_stop || i_meas_err) begin
            state <= ST_READY;
          end else if (tmr_end(tmr, ROT_CYC)) begin
            tmr <= '0;
            state <= ST_SPIN;
          end
        end
        ST_SPIN: begin
          tmr <= tmr + 1'b1;
          if (i_key_stop || i_meas_err || tmr_end(tmr, ROT_CYC)) begin
            state <= ST_READY;
          end
        end
        ST_ENERGISE: begin
          tmr <= tmr + 1'b1;
          if (i_key_stop || i_meas_err || tmr_end(tmr, STAT_CYC)) begin
            state <= ST_READY;
          end
        end
        default: state <= ST_PROG;
      endcase
    end
  end

  assign ev_cancel = i_ce && busy && (i_key_stop || i_meas_err);
  assign ev_done = i_ce && !ev_cancel &&
                   ((state == ST_SPIN && tmr_end(tmr, ROT_CYC)) ||
                    (state == ST_ENERGISE && tmr_end(tmr, STAT_CYC)));

  // resistance constant: saved at start, stored at end, restored on cancel
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      winding_resistance_const <= '0;
      resist_saved <= '0;
    end else if (i_ce) begin
      if (state == ST_READY && i_key_run && !i_key_stop && !i_display_key) begin
        resist_saved <= winding_resistance_const;
      end
      if (busy) begin
        winding_resistance_const <= i_meas_resist; // tracked live while measuring
      end
      if (ev_done) begin
        winding_resistance_const <= i_meas_resist;
      end else if (ev_cancel) begin
        winding_resistance_const <= resist_saved;
      end else if (!busy && do_write && w_strb[0] && aw_addr == ADDR_RESIST) begin
        winding_resistance_const <= w_data[15:0];
      end
    end
  end

  // sticky interrupt flags; set beats a same-cycle write-one clear
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_stat <= '0;
      o_err_ind <= 1'b0;
    end else if (i_ce) begin
      if (do_write && w_strb[0] && aw_addr == ADDR_IRQ_STAT) begin
        irq_stat <= irq_stat & ~w_data[IRQ_W-1:0];
      end
      if (ev_done) irq_stat[IRQ_DONE] <= 1'b1;
      if (ev_cancel) irq_stat[IRQ_CANCEL] <= 1'b1;
      if (ev_err) irq_stat[IRQ_ERR] <= 1'b1;
      if (ev_err) begin
        o_err_ind <= 1'b1;
      end else if (state != ST_PROG || (do_write && aw_addr == ADDR_TUNE)) begin
        o_err_ind <= 1'b0;
      end
    end
  end
  assign o_irq = |(irq_stat & irq_mask);

  // multi-function io; stationary freezes outputs at their start value
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mf_out_frozen <= '0;
      o_mf_out <= '0;
      o_mf_in_eff <= '0;
    end else if (i_ce) begin
      if (!busy) mf_out_frozen <= i_mf_out_norm;
      o_mf_out <= (state == ST_ENERGISE) ? mf_out_frozen : i_mf_out_norm;
      o_mf_in_eff <= busy ? 8'h00 : i_mf_in;
    end
  end

  assign o_tuning = busy;
  assign o_motor_energise = busy;
  assign o_motor_rotate = (state == ST_SPIN);

  frac_ref_mux u_mux (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_remote(i_remote),
    .i_local_src(local_ref_source_sel),
    .i_remote_src(remote_ref_source_sel),
    .i_pot(i_pot),
    .i_keyed(keyed_ref),
    .i_preset(preset_freq_ref_one),
    .i_volt(i_volt),
    .i_cur420(i_cur420),
    .i_cur020(i_cur020),
    .i_pulse(i_pulse),
    .i_comm(i_comm),
    .i_conn_volt(i_conn_volt),
    .i_conn_cur(i_conn_cur),
    .i_card(i_card),
    .o_ref(o_freq_ref)
  );

  a_no_tune_m2: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && state == ST_PROG && i_motor2_sel) |=> state == ST_PROG)
    else $error("tuning entered with motor 2");
  a_tune_mode_kept: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && do_write && w_strb[0] && aw_addr == ADDR_TUNE && i_motor2_sel)
    |=> $stable(tuning_mode_sel) && o_err_ind) else $error("mode changed under motor 2");
  a_inputs_masked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && busy) |=> o_mf_in_eff == 8'h00) else $error("inputs passed while tuning");
  a_outputs_frozen: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && state == ST_ENERGISE) |=> o_mf_out == $past(mf_out_frozen))
    else $error("outputs not frozen");
  a_cancel_restore: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ev_cancel |=> winding_resistance_const == $past(resist_saved) && state == ST_READY)
    else $error("constant not restored");
  a_cfg_locked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (busy && i_ce) |=> $stable(remote_ref_source_sel) && $stable(local_ref_source_sel))
    else $error("selection changed while tuning");
  a_hold_to_spin: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && state == ST_HOLD && !i_key_stop && !i_meas_err && tmr_end(tmr, ROT_CYC))
    |=> state == ST_SPIN && o_motor_rotate) else $error("hold phase did not end");
  a_stat_done: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && state == ST_ENERGISE && !i_key_stop && !i_meas_err && tmr_end(tmr, STAT_CYC))
    |=> state == ST_READY && irq_stat[IRQ_DONE]) else $error("stationary did not end");
  a_keyed_commit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && state == ST_PROG && i_key_value_upd && !i_key_enter && !enter_commit_option)
    |=> $stable(keyed_ref)) else $error("value taken without enter");
  a_local_sel: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ce && !i_remote && local_ref_source_sel == LOCAL_SRC_POT) |=> o_freq_ref == $past(i_pot))
    else $error("local pot not routed");
endmodule

// ---- rtl/frac_pkg.sv ----
// frac_pkg: constants, register map and state types for the reference
// selector and tuning controller. assumes a 100 MHz clock.
package frac_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_TUNE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_PRESET = 8'h14;
  localparam logic [7:0] ADDR_RESIST = 8'h18;
  localparam logic [7:0] ADDR_KEYED = 8'h1c;
  // config field positions
  localparam int CFG_LOCAL_BIT = 0;
  localparam int CFG_ENTER_BIT = 1;
  localparam int CFG_REM_LSB = 4;
  localparam int CFG_REM_W = 4;
  localparam int REF_W = 16;
  // reset source codes and write limits
  localparam logic LOCAL_SRC_POT = 1'b0;
  localparam logic LOCAL_SRC_KEYPAD = 1'b1;
  localparam logic [3:0] REM_SRC_POT = 4'h0;
  localparam logic [3:0] REM_SRC_PRESET = 4'h1;
  localparam logic [3:0] REM_SRC_MAX = 4'h9;
  localparam logic [1:0] TUNE_MAX = 2'h2;
  // irq bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_CANCEL = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_W = 3;
  // timing
  localparam longint CLK_HZ = 100000000;
  localparam longint ROT_PHASE_S = 60;
  localparam longint STAT_PHASE_S = 20;
  localparam longint ROT_PHASE_CYC = ROT_PHASE_S * CLK_HZ;
  localparam longint STAT_PHASE_CYC = STAT_PHASE_S * CLK_HZ;
  localparam int TMR_W = 34;

  typedef enum logic [1:0] {
    TUNE_OFF = 2'b00,
    TUNE_ROT = 2'b01,
    TUNE_STAT = 2'b10
  } frac_tune_t;

  typedef enum logic [2:0] {
    ST_PROG = 3'b000,
    ST_READY = 3'b001,
    ST_HOLD = 3'b010,
    ST_SPIN = 3'b011,
    ST_ENERGISE = 3'b100
  } frac_state_t;
endpackage

// ---- rtl/frac_ref_mux.sv ----
// frac_ref_mux: registered frequency reference selector.
// assumes all source inputs are synchronous to i_ref_clk.
`timescale 1ns/1ps
module frac_ref_mux
  import frac_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_remote,
  input wire logic i_local_src,
  input wire logic [3:0] i_remote_src,
  input wire logic [frac_pkg::REF_W-1:0] i_pot,
  input wire logic [frac_pkg::REF_W-1:0] i_keyed,
  input wire logic [frac_pkg::REF_W-1:0] i_preset,
  input wire logic [frac_pkg::REF_W-1:0] i_volt,
  input wire logic [frac_pkg::REF_W-1:0] i_cur420,
  input wire logic [frac_pkg::REF_W-1:0] i_cur020,
  input wire logic [frac_pkg::REF_W-1:0] i_pulse,
  input wire logic [frac_pkg::REF_W-1:0] i_comm,
  input wire logic [frac_pkg::REF_W-1:0] i_conn_volt,
  input wire logic [frac_pkg::REF_W-1:0] i_conn_cur,
  input wire logic [frac_pkg::REF_W-1:0] i_card,
  output logic [frac_pkg::REF_W-1:0] o_ref
);
  import frac_pkg::*;
  logic [REF_W-1:0] next_ref;

  // one flat choice, so no intermediate source appears on mode change
  always_comb begin
    next_ref = '0;
    if (!i_remote) begin
      next_ref = (i_local_src == LOCAL_SRC_POT) ? i_pot : i_keyed;
    end else begin
      case (i_remote_src)
        4'h0: next_ref = i_pot;
        4'h1: next_ref = i_preset;
        4'h2: next_ref = i_volt;
        4'h3: next_ref = i_cur420;
        4'h4: next_ref = i_cur020;
        4'h5: next_ref = i_pulse;
        4'h6: next_ref = i_comm;
        4'h7: next_ref = i_conn_volt;
        4'h8: next_ref = i_conn_cur;
        4'h9: next_ref = i_card;
        default: next_ref = '0;
      endcase
    end
  end

  // registered output switches the cycle after the mode changes
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ref <= '0;
    end else if (i_ce) begin
      o_ref <= next_ref;
    end
  end

  a_ref_follow: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce |=> o_ref == $past(next_ref)) else $error("reference did not follow");
endmodule

// ---- tb/frac_panel_model.sv ----
// frac_panel_model: operator keypad and the external reference sources.
// assumes the bench calls its tasks from the i_ref_clk domain.
`timescale 1ns/1ps
module frac_panel_model
  import frac_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [7:0] i_lvl,
  output logic [frac_pkg::REF_W-1:0] o_pot,
  output logic [frac_pkg::REF_W-1:0] o_volt,
  output logic [frac_pkg::REF_W-1:0] o_cur420,
  output logic [frac_pkg::REF_W-1:0] o_cur020,
  output logic [frac_pkg::REF_W-1:0] o_pulse,
  output logic [frac_pkg::REF_W-1:0] o_comm,
  output logic [frac_pkg::REF_W-1:0] o_conn_volt,
  output logic [frac_pkg::REF_W-1:0] o_conn_cur,
  output logic [frac_pkg::REF_W-1:0] o_card,
  output logic o_key_run,
  output logic o_key_stop,
  output logic o_display_key,
  output logic o_key_enter,
  output logic [frac_pkg::REF_W-1:0] o_key_value,
  output logic o_key_value_upd
);
  // distinct upper bytes, so a wrong mux leg can never look right
  assign o_pot = {8'h01, i_lvl};
  assign o_volt = {8'h02, i_lvl};
  assign o_cur420 = {8'h03, i_lvl};
  assign o_cur020 = {8'h04, i_lvl};
  assign o_pulse = {8'h05, i_lvl};
  assign o_comm = {8'h06, i_lvl};
  assign o_conn_volt = {8'h07, i_lvl};
  assign o_conn_cur = {8'h08, i_lvl};
  assign o_card = {8'h09, i_lvl};

  // keys idle low
  initial begin
    {o_key_run, o_key_stop, o_display_key, o_key_enter, o_key_value_upd} = 5'h00;
    o_key_value = 16'hffff;
  end

  // one-cycle key pulse; k: 0 run, 1 stop, 2 display
  task automatic press(input int k);
    @(posedge i_ref_clk);
    o_key_run <= (k == 0);
    o_key_stop <= (k == 1);
    o_display_key <= (k == 2);
    @(posedge i_ref_clk);
    {o_key_run, o_key_stop, o_display_key} <= 3'h0;
  endtask

  // keyed value for one cycle, then the bus shows junk, not the old value
  task automatic key_in(input logic [15:0] v, input logic e);
    @(posedge i_ref_clk);
    o_key_value <= v;
    o_key_value_upd <= 1'b1;
    o_key_enter <= e;
    @(posedge i_ref_clk);
    o_key_value_upd <= 1'b0;
    o_key_enter <= 1'b0;
    o_key_value <= ~v;
  endtask
endmodule

// ---- tb/frac_ctrl_tb.sv ----
// frac_ctrl_tb: self-checking bench for the reference selector and tuner.
// assumes short tuning phases (20 cycles) and a non-pot panel.
`timescale 1ns/1ps
module frac_ctrl_tb;
  import frac_pkg::*;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_remote = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic i_key_run, i_key_stop, i_display_key, i_key_enter, i_key_value_upd;
  logic o_err_ind, o_tuning, o_motor_energise, o_motor_rotate;
  logic [15:0] i_key_value, i_pot, i_volt, i_cur420, i_cur020, i_pulse, i_comm;
  logic [15:0] i_conn_volt, i_conn_cur, i_card, o_freq_ref;
  logic [7:0] i_mf_in = 8'h00, o_mf_in_eff, i_mf_out_norm = 8'h00, o_mf_out;
  logic i_motor2_sel = 1'b0, i_meas_err = 1'b0;
  logic [15:0] i_meas_resist = 16'h0000, rnd = 16'h0030, r0;
  logic [7:0] lvl = 8'h00;
  logic [31:0] exp_q[$];
  int err_total = 0, tests_run = 0, cyc = 0;

  frac_ctrl #(.POT_PANEL(1'b0), .ROT_CYC(20), .STAT_CYC(20)) dut_u (
    .i_ref_clk, .i_rst, .i_ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_irq, .i_remote,
    .i_key_run, .i_key_stop, .i_display_key, .i_key_enter, .i_key_value,
    .i_key_value_upd, .o_err_ind, .o_tuning, .i_pot, .i_volt, .i_cur420, .i_cur020,
    .i_pulse, .i_comm, .i_conn_volt, .i_conn_cur, .i_card, .o_freq_ref, .i_mf_in,
    .o_mf_in_eff, .i_motor2_sel, .i_mf_out_norm, .o_mf_out, .i_meas_resist,
    .i_meas_err, .o_motor_energise, .o_motor_rotate);

  frac_panel_model panel_u (.i_ref_clk, .i_lvl(lvl), .o_pot(i_pot), .o_volt(i_volt),
    .o_cur420(i_cur420), .o_cur020(i_cur020), .o_pulse(i_pulse), .o_comm(i_comm),
    .o_conn_volt(i_conn_volt), .o_conn_cur(i_conn_cur), .o_card(i_card),
    .o_key_run(i_key_run), .o_key_stop(i_key_stop), .o_display_key(i_display_key),
    .o_key_enter(i_key_enter), .o_key_value(i_key_value),
    .o_key_value_upd(i_key_value_upd));

  always #5 i_ref_clk = ~i_ref_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // expected reference per remote code; code 1 is the preset register
  function automatic logic [15:0] src(input int c, input logic [15:0] p);
    if (c == 0) return {8'h01, lvl};
    if (c == 1) return p;
    return {8'(c), lvl};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // n edges, then settle to the falling edge so registered outputs are stable
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask

  // ready is sampled mid-cycle; it only moves at rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    @(posedge i_ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge i_ref_clk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid;
      @(posedge i_ref_clk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end while (!b_hit);
    s_axi_bready <= 1'b0;
  endtask

  // read: the expectation is noted first, the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic hit;
    exp_q.push_back(e);
    @(posedge i_ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge i_ref_clk);
      hit = s_axi_arvalid && s_axi_arready;
      @(posedge i_ref_clk);
      if (hit) s_axi_arvalid <= 1'b0;
    end while (!hit);
    do @(negedge i_ref_clk); while (s_axi_rvalid !== 1'b1);
    @(posedge i_ref_clk);
  endtask

  // read monitor: rvalid stands one cycle since rready is held high
  always @(negedge i_ref_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) check(s_axi_rdata, exp_q.pop_front());
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rnd = lfsr(rnd);
    lvl <= rnd[7:0];
    rd(ADDR_CFG, 32'h11);
    rd(ADDR_TUNE, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(8'h20, 32'h0);
    rnd = lfsr(rnd);
    r0 = rnd;
    panel_u.key_in(r0, 1'b1);
    wait_n(3);
    check(o_freq_ref, r0);
    rnd = lfsr(rnd);
    panel_u.key_in(rnd, 1'b0);
    wait_n(3);
    check(o_freq_ref, r0);
    wr(ADDR_CFG, 32'h13);
    rnd = lfsr(rnd);
    panel_u.key_in(rnd, 1'b0);
    wait_n(3);
    check(o_freq_ref, rnd);
    wr(ADDR_CFG, 32'h12);
    wait_n(2);
    check(o_freq_ref, {8'h01, lvl});
    @(posedge i_ref_clk);
    i_remote <= 1'b1;
    rnd = lfsr(rnd);
    wr(ADDR_PRESET, {16'h0, rnd});
    for (int c = 0; c < 10; c++) begin
      wr(ADDR_CFG, {24'h0, 4'(c), 4'h2});
      wait_n(2);
      check(o_freq_ref, src(c, rnd));
    end
    wr(ADDR_CFG, 32'ha2);
    rd(ADDR_CFG, 32'h92);
    @(posedge i_ref_clk);
    i_remote <= 1'b0;
    @(negedge i_ref_clk);
    check(o_freq_ref, {8'h09, lvl});
    @(negedge i_ref_clk);
    check(o_freq_ref, {8'h01, lvl});
    // stationary run: inputs masked, outputs frozen, writes locked
    @(posedge i_ref_clk);
    i_mf_in <= rnd[7:0] | 8'h01;
    i_mf_out_norm <= 8'h5a;
    i_meas_resist <= 16'h1234;
    wr(ADDR_TUNE, 32'h2);
    panel_u.press(2);
    panel_u.press(0);
    wait_n(2);
    check(o_tuning, 1'b1);
    check(o_motor_energise, 1'b1);
    check(o_mf_in_eff, 8'h00);
    @(posedge i_ref_clk);
    i_mf_out_norm <= 8'ha5;
    wr(ADDR_CFG, 32'h03);
    wait_n(0);
    check(o_mf_out, 8'h5a);
    rd(ADDR_CFG, 32'h92);
    wait_n(20);
    check(o_tuning, 1'b0);
    rd(ADDR_RESIST, 32'h1234);
    // rotational run, then cancel from the spin phase
    panel_u.press(2);
    wr(ADDR_TUNE, 32'h1);
    panel_u.press(2);
    panel_u.press(0);
    @(posedge i_ref_clk);
    i_meas_resist <= 16'h4321;
    i_mf_out_norm <= 8'h3c;
    wait_n(3);
    check(o_motor_rotate, 1'b0);
    check(o_mf_out, 8'h3c);
    check(o_mf_in_eff, 8'h00);
    wait_n(20);
    check(o_motor_rotate, 1'b1);
    panel_u.press(1);
    wait_n(2);
    check(o_tuning, 1'b0);
    rd(ADDR_RESIST, 32'h1234);
    // motor 2 selected: write refused, tuning mode not entered
    panel_u.press(2);
    @(posedge i_ref_clk);
    i_motor2_sel <= 1'b1;
    wr(ADDR_TUNE, 32'h2);
    rd(ADDR_TUNE, 32'h1);
    wait_n(0);
    check(o_err_ind, 1'b1);
    panel_u.press(2);
    panel_u.press(0);
    wait_n(2);
    check(o_tuning, 1'b0);
    rd(ADDR_STAT, 32'h10);
    // done, cancel and error flags: mask, raise, clear
    rd(ADDR_IRQ_STAT, 32'h7);
    wait_n(0);
    check(o_irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h4);
    wait_n(0);
    check(o_irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h7);
    wait_n(0);
    check(o_irq, 1'b0);
    rd(ADDR_IRQ_STAT, 32'h0);
    report_and_stop();
  end
endmodule
